// ===== seq_map.vh
// Opcodes, field widths, reset values and sizes of the microsequencer
`ifndef SEQ_MAP_VH
`define SEQ_MAP_VH
`define ADDR_W        8
`define BOOT_ADDR     8'h00
`define OP_W          4
`define OP_CONTINUE   4'h0
`define OP_JUMP       4'h1
`define OP_CALL       4'h2
`define OP_RETURN     4'h3
`define OP_LOAD_COUNTER_OP      4'h4
`define OP_LOOP       4'h5
`define OP_DEC        4'h6
`define OP_SAVELOAD   4'h7
`define OP_RESTORE    4'h8
`define OP_PUSHK      4'h9
`define OP_PUSHIN     4'ha
`define WORD_W        32
`define F_OUT_LSB     0
`define F_OUT_W       8
`define F_Q_LSB       8
`define F_D_LSB       16
`define F_OP_LSB      24
`define STACK_DEPTH   4
`define STACK_PTR_W   3
`define MWB_BASE      8'hc8
`define MWB_TOP       8'hcf
`define REL_EDGES     2'h3
`endif

// ===== seq_stack.v
// Return stack of the microsequencer
`timescale 1ns/1ns
`default_nettype none
`include "seq_map.vh"
module seq_stack (
  input  wire                 core_clk,
  input  wire                 resetn,
  input  wire                 push,
  input  wire                 pop,
  input  wire [`ADDR_W-1:0]   push_data,
  output wire [`ADDR_W-1:0]   top
);
  reg [`ADDR_W-1:0]     mem_reg [0:`STACK_DEPTH-1];
  reg [`STACK_PTR_W-1:0] ptr_reg;
  wire [`STACK_PTR_W-1:0] top_idx;
  integer i;

  assign top_idx = ptr_reg - 3'h1;
  // Empty stack reads as the boot address rather than stale data
  assign top = (ptr_reg == 3'h0) ? `BOOT_ADDR : mem_reg[top_idx[1:0]];

  // Overflow drops the oldest entry view by wrapping; software keeps depth in bounds
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      ptr_reg <= 3'h0;
      for (i = 0; i < `STACK_DEPTH; i = i + 1) begin
        mem_reg[i] <= 8'h00;
      end
    end else if (push && pop) begin
      mem_reg[top_idx[1:0]] <= push_data;
    end else if (push) begin
      mem_reg[ptr_reg[1:0]] <= push_data;
      if (ptr_reg != 3'h4) begin
        ptr_reg <= ptr_reg + 3'h1;
      end
    end else if (pop && ptr_reg != 3'h0) begin
      ptr_reg <= ptr_reg - 3'h1;
    end
  end
endmodule // seq_stack
`default_nettype wire

// ===== seq_control.v
// Next-state control of the EPROM microsequencer
// Summary of operation
// - Addresses and constant fields are eight bits wide.
// - Continue takes the next sequential word; stack and counter hold.
// - Jump goes to the first label; stack and counter hold.
// - Call pushes the second label and goes to the first label.
// - Return goes to the stack top and pops it in the same step.
// - Load counter writes the constant and goes to the first label.
// - Loop: nonzero decrements and goes first label; zero goes second label.
// - Decrement if nonzero, always going to the first label.
// - Save-and-load pushes counter, loads constant, goes to first label.
// - Restore pops the stack into the counter, goes to first label.
// - Push constant onto the stack, counter held, go first label.
// - Push inputs captures all eight inputs as one stack entry.
// - Destinations in the multi-way block pick one of four words from inputs.
// - Security bit blocks readback; only a full erase or the core reset clears it.
// - Reset is sampled on the clock edge and can raise supervisor entry.
// - Reset starts at boot address; boot outputs stay through the third edge after release.
`timescale 1ns/1ns
`default_nettype none
`include "seq_map.vh"
module seq_control (
  input  wire                 core_clk,
  input  wire                 resetn,
  input  wire                 active_low_reset,
  input  wire [7:0]           general_inputs,
  input  wire [1:0]           branch_select,
  input  wire                 security_bit,
  input  wire                 full_erase,
  input  wire                 readback_req,
  input  wire [`ADDR_W-1:0]   readback_addr,
  input  wire [`WORD_W-1:0]   prom_word,
  output wire [`ADDR_W-1:0]   prom_addr,
  output reg  [`F_OUT_W-1:0]  user_outputs,
  output reg  [`ADDR_W-1:0]   state_addr,
  output reg  [`ADDR_W-1:0]   counter_value,
  output reg                  counter_zero,
  output reg                  supervisor_entry,
  output reg                  secured,
  output reg  [`WORD_W-1:0]   readback_data
);
  reg  [`WORD_W-1:0]  pipe_reg;
  reg  [`ADDR_W-1:0]  cnt_reg;
  reg  [`ADDR_W-1:0]  cnt_next;
  reg  [`ADDR_W-1:0]  addr_next;
  reg                 push;
  reg                 pop;
  reg  [`ADDR_W-1:0]  push_data;
  reg  [1:0]          rel_reg;
  reg  [2:0]          rst_sync_reg;
  reg  [7:0]          in_s1_reg;
  reg  [7:0]          in_s2_reg;
  reg  [7:0]          in_s3_reg;
  reg  [7:0]          in_ok_reg;
  reg  [1:0]          bsel_s1_reg;
  reg  [1:0]          bsel_s2_reg;
  reg  [1:0]          bsel_s3_reg;
  reg  [1:0]          bsel_ok_reg;
  reg                 sec_reg;
  wire [`ADDR_W-1:0]  stack_top;
  wire [`OP_W-1:0]    op;
  wire [`ADDR_W-1:0]  q_field;
  wire [`ADDR_W-1:0]  d_field;
  wire                cnt_nz;
  wire                in_mwb;
  wire                boot_hold;
  genvar g;

  assign op      = pipe_reg[`F_OP_LSB +: `OP_W];
  assign q_field = pipe_reg[`F_Q_LSB +: `ADDR_W];
  assign d_field = pipe_reg[`F_D_LSB +: `ADDR_W];
  assign cnt_nz  = (cnt_reg != 8'h00);
  // Multi-way block occupies groups of four words; low two bits chosen by inputs
  assign in_mwb  = (addr_next >= `MWB_BASE) && (addr_next <= `MWB_TOP);
  assign boot_hold = (rel_reg != 2'h0);
  // Fetch address; readback shares the array port only while unsecured
  assign prom_addr = (readback_req && !sec_reg) ? readback_addr :
                     (boot_hold ? `BOOT_ADDR :
                     (in_mwb ? {addr_next[7:2], bsel_ok_reg} : addr_next));

  seq_stack u_stack (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .push      (push),
    .pop       (pop),
    .push_data (push_data),
    .top       (stack_top)
  );

  // Inputs from outside the clock domain: three stages, accept when stages two and three agree
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_insync
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          in_s1_reg[g] <= 1'b0;
          in_s2_reg[g] <= 1'b0;
          in_s3_reg[g] <= 1'b0;
          in_ok_reg[g] <= 1'b0;
        end else begin
          in_s1_reg[g] <= general_inputs[g];
          in_s2_reg[g] <= in_s1_reg[g];
          in_s3_reg[g] <= in_s2_reg[g];
          if (in_s2_reg[g] == in_s3_reg[g]) begin
            in_ok_reg[g] <= in_s3_reg[g];
          end
        end
      end
    end
    for (g = 0; g < 2; g = g + 1) begin : g_bsync
      always @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          bsel_s1_reg[g] <= 1'b0;
          bsel_s2_reg[g] <= 1'b0;
          bsel_s3_reg[g] <= 1'b0;
          bsel_ok_reg[g] <= 1'b0;
        end else begin
          bsel_s1_reg[g] <= branch_select[g];
          bsel_s2_reg[g] <= bsel_s1_reg[g];
          bsel_s3_reg[g] <= bsel_s2_reg[g];
          if (bsel_s2_reg[g] == bsel_s3_reg[g]) begin
            bsel_ok_reg[g] <= bsel_s3_reg[g];
          end
        end
      end
    end
  endgenerate

  always @* begin
    addr_next = state_addr + 8'h01;
    cnt_next  = cnt_reg;
    push      = 1'b0;
    pop       = 1'b0;
    push_data = d_field;
    case (op)
      `OP_CONTINUE: begin
        addr_next = state_addr + 8'h01;
      end
      `OP_JUMP: begin
        addr_next = q_field;
      end
      `OP_CALL: begin
        addr_next = q_field;
        push      = 1'b1;
        push_data = d_field;
      end
      `OP_RETURN: begin
        addr_next = stack_top;
        pop       = 1'b1;
      end
      `OP_LOAD_COUNTER_OP: begin
        addr_next = q_field;
        cnt_next  = d_field;
      end
      `OP_LOOP: begin
        if (cnt_nz) begin
          addr_next = q_field;
          cnt_next  = cnt_reg - 8'h01;
        end else begin
          addr_next = d_field;
        end
      end
      `OP_DEC: begin
        addr_next = q_field;
        if (cnt_nz) begin
          cnt_next = cnt_reg - 8'h01;
        end
      end
      `OP_SAVELOAD: begin
        addr_next = q_field;
        push      = 1'b1;
        push_data = cnt_reg;
        cnt_next  = d_field;
      end
      `OP_RESTORE: begin
        addr_next = q_field;
        pop       = 1'b1;
        cnt_next  = stack_top;
      end
      `OP_PUSHK: begin
        addr_next = q_field;
        push      = 1'b1;
        push_data = d_field;
      end
      `OP_PUSHIN: begin
        addr_next = q_field;
        push      = 1'b1;
        push_data = in_ok_reg;
      end
      default: begin
        addr_next = state_addr + 8'h01;
      end
    endcase
    // Boot word is repeated while held, so its effects must not run
    if (boot_hold) begin
      push     = 1'b0;
      pop      = 1'b0;
      cnt_next = cnt_reg;
    end
  end

  // Reset pin sampled like any other input; the core reset stays asynchronous
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rst_sync_reg     <= 3'h7;
      supervisor_entry <= 1'b0;
    end else begin
      rst_sync_reg     <= {rst_sync_reg[1:0], active_low_reset};
      supervisor_entry <= (rst_sync_reg[2:1] == 2'b00);
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      rel_reg <= `REL_EDGES;
    end else if (rst_sync_reg[2:1] == 2'b00) begin
      rel_reg <= `REL_EDGES;
    end else if (boot_hold) begin
      rel_reg <= rel_reg - 2'h1;
    end
  end

  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      pipe_reg      <= {`WORD_W{1'b0}};
      state_addr    <= `BOOT_ADDR;
      cnt_reg       <= 8'h00;
      user_outputs  <= 8'h00;
      counter_value <= 8'h00;
      counter_zero  <= 1'b1;
      readback_data <= 32'h00000000;
    end else begin
      pipe_reg      <= prom_word;
      state_addr    <= prom_addr[7:0];
      cnt_reg       <= cnt_next;
      user_outputs  <= prom_word[`F_OUT_LSB +: `F_OUT_W];
      counter_value <= cnt_next;
      counter_zero  <= (cnt_next == 8'h00);
      // Secured part returns zeros instead of array contents
      readback_data <= (readback_req && !sec_reg) ? prom_word : 32'h00000000;
    end
  end

  // Security latch: only erase or the core reset clears it, programming sets it
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      sec_reg <= 1'b0;
      secured <= 1'b0;
    end else begin
      // Status copy moves on the same edge as the latch, so it never lags an erase
      if (full_erase) begin
        sec_reg <= 1'b0;
        secured <= 1'b0;
      end else if (security_bit) begin
        sec_reg <= 1'b1;
        secured <= 1'b1;
      end
    end
  end
endmodule // seq_control
`default_nettype wire

// ===== seq_control_sva.sv
// Assertion checker for the microsequencer next-state control
`timescale 1ns/1ns
`default_nettype none
`include "seq_map.vh"
module seq_control_chk (
  input wire logic        core_clk,
  input wire logic        resetn,
  input wire logic        active_low_reset,
  input wire logic        full_erase,
  input wire logic        readback_req,
  input wire logic [31:0] prom_word,
  input wire logic [7:0]  prom_addr,
  input wire logic [7:0]  counter_value,
  input wire logic        counter_zero,
  input wire logic        secured
);
  // Readback may borrow the fetch address, so checks pause while it runs
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn || readback_req);
  logic [3:0] qt_reg;
  wire  [3:0] op = prom_word[27:24];
  wire  [7:0] q  = prom_word[15:8];
  wire  [7:0] d  = prom_word[23:16];
  // Boot hold and supervisor reload steer the fetch address for a few edges
  wire        g  = qt_reg >= 4'hc && !(q >= `MWB_BASE && q <= `MWB_TOP);
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) qt_reg <= 4'h0;
    else if (!active_low_reset || readback_req) qt_reg <= 4'h0;
    else if (qt_reg != 4'hf) qt_reg <= qt_reg + 4'h1;
  end
  sequence s_loop_nz; g && op == `OP_LOOP ##1 counter_value != 8'h00; endsequence
  sequence s_loop_z; g && op == `OP_LOOP ##1 counter_value == 8'h00; endsequence
  sequence s_dec_nz; g && op == `OP_DEC ##1 counter_value != 8'h00; endsequence
  sequence s_push_ret; g && op == `OP_PUSHK ##1 op == `OP_RETURN; endsequence
  property p_zf; counter_zero == (counter_value == 8'h00); endproperty
  property p_cont; g && op == `OP_CONTINUE |=> prom_addr == $past(prom_addr) + 8'h01; endproperty
  property p_jump; g && op == `OP_JUMP |=> prom_addr == $past(q) ##1 counter_value == $past(counter_value);
  endproperty
  property p_call; g && op == `OP_CALL |=> prom_addr == $past(q); endproperty
  property p_load_counter_op; g && op == `OP_LOAD_COUNTER_OP |=> prom_addr == $past(q) ##1 counter_value == $past(d, 2); endproperty
  property p_loop_nz; s_loop_nz |-> prom_addr == $past(q) ##1 counter_value == $past(counter_value) - 8'h01;
  endproperty
  property p_loop_z; s_loop_z |-> prom_addr == $past(d) ##1 counter_value == 8'h00; endproperty
  property p_dec; s_dec_nz |-> prom_addr == $past(q) ##1 counter_value == $past(counter_value) - 8'h01; endproperty
  property p_push_ret; s_push_ret |=> prom_addr == $past(d, 2); endproperty
  property p_erase; full_erase |=> !secured; endproperty
  a_zf: assert property (p_zf) else $error("zero flag wrong");
  a_cont: assert property (p_cont) else $error("continue target wrong");
  a_jump: assert property (p_jump) else $error("jump wrong");
  a_call: assert property (p_call) else $error("call target wrong");
  a_load_counter_op: assert property (p_load_counter_op) else $error("load counter wrong");
  a_loop_nz: assert property (p_loop_nz) else $error("loop nonzero wrong");
  a_loop_z: assert property (p_loop_z) else $error("loop zero wrong");
  a_dec: assert property (p_dec) else $error("decrement wrong");
  a_push_ret: assert property (p_push_ret) else $error("return after push wrong");
  a_erase: assert property (p_erase) else $error("erase left security set");
endmodule // seq_control_chk
bind seq_control seq_control_chk chk (.core_clk(core_clk), .resetn(resetn), .active_low_reset(active_low_reset),
  .full_erase(full_erase), .readback_req(readback_req), .prom_word(prom_word), .prom_addr(prom_addr),
  .counter_value(counter_value), .counter_zero(counter_zero), .secured(secured));
`default_nettype wire

// ===== ext_logic.sv
// Program array and synchronous input logic beside the microsequencer
`timescale 1ns/1ns
`default_nettype none
`include "seq_map.vh"
module ext_logic (
  input  wire logic        core_clk,
  input  wire logic [7:0]  prom_addr,
  output wire logic [31:0] prom_word,
  output var  logic [7:0]  general_inputs,
  output var  logic [1:0]  branch_select
);
  logic [31:0] mem_reg [0:255];
  integer      i;
  function automatic logic [31:0] w(input logic [3:0] o, input logic [7:0] d, input logic [7:0] q);
    w = {4'h0, o, d, q, q};
  endfunction
  assign prom_word = mem_reg[prom_addr];
  // Unprogrammed words read as zero, which is a plain continue
  initial begin
    for (i = 0; i < 256; i = i + 1) mem_reg[i] = 32'h0000_0000;
    mem_reg[8'h0c] = {w(`OP_LOAD_COUNTER_OP, 8'h03, 8'h10)} & 32'hffff_ff00 | 32'h0000_000c;
    mem_reg[8'h10] = w(`OP_LOOP, 8'h11, 8'h10);
    mem_reg[8'h12] = w(`OP_CALL, 8'h60, 8'h20);
    mem_reg[8'h20] = w(`OP_LOAD_COUNTER_OP, 8'h09, 8'h21);
    mem_reg[8'h21] = w(`OP_SAVELOAD, 8'h05, 8'h22);
    mem_reg[8'h22] = w(`OP_DEC, 8'h00, 8'h23);
    mem_reg[8'h23] = w(`OP_RESTORE, 8'h00, 8'h24);
    mem_reg[8'h24] = w(`OP_DEC, 8'h00, 8'h25);
    // Pushed constant differs from the call's return entry, so a lost push shows up
    mem_reg[8'h25] = w(`OP_PUSHK, 8'h13, 8'h30) & 32'hffff_ff00 | 32'h0000_0025;
    mem_reg[8'h30] = w(`OP_RETURN, 8'h00, 8'h30);
    mem_reg[8'h13] = w(`OP_PUSHIN, 8'h00, 8'h14) & 32'hffff_ff00 | 32'h0000_0013;
    mem_reg[8'h14] = w(`OP_RETURN, 8'h00, 8'h14);
    mem_reg[8'h40] = w(`OP_JUMP, 8'h00, 8'hc8) & 32'hffff_ff00 | 32'h0000_0040;
    mem_reg[8'hca] = w(`OP_JUMP, 8'h00, 8'h50) & 32'hffff_ff00 | 32'h0000_00ca;
    mem_reg[8'h50] = w(`OP_JUMP, 8'h00, 8'h50);
    general_inputs = 8'h40;
    branch_select = 2'h2;
  end
  // Inputs only move just after the edge, well clear of the setup window
  always @(posedge core_clk) begin
    general_inputs <= #1 8'h40;
    branch_select <= #1 2'h2;
  end
endmodule // ext_logic
`default_nettype wire

// ===== tb_top.sv
// Self-checking testbench for the microsequencer next-state control
`timescale 1ns/1ns
`default_nettype none
`include "seq_map.vh"
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin bad_count++; \
  $display("unexpected at %0t: got %h expected %h", $time, a, e); end end
module tb_top;
  logic        core_clk, resetn, active_low_reset, security_bit, full_erase, readback_req;
  logic        counter_zero, supervisor_entry, secured;
  logic [7:0]  readback_addr, general_inputs, prom_addr, user_outputs, state_addr, counter_value;
  logic [1:0]  branch_select;
  logic [31:0] prom_word, readback_data;
  int          bad_count = 0;
  int          n_checks = 0;
  int          k;
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  seq_control uut (.core_clk(core_clk), .resetn(resetn), .active_low_reset(active_low_reset),
    .general_inputs(general_inputs), .branch_select(branch_select), .security_bit(security_bit),
    .full_erase(full_erase), .readback_req(readback_req), .readback_addr(readback_addr), .prom_word(prom_word),
    .prom_addr(prom_addr), .user_outputs(user_outputs), .state_addr(state_addr), .counter_value(counter_value),
    .counter_zero(counter_zero), .supervisor_entry(supervisor_entry), .secured(secured),
    .readback_data(readback_data));
  ext_logic far (.core_clk(core_clk), .prom_addr(prom_addr), .prom_word(prom_word),
    .general_inputs(general_inputs), .branch_select(branch_select));
  task finish_test;
    if (bad_count == 0 && n_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task step(input logic [7:0] a, input logic [7:0] c);
    @(posedge core_clk);
    #1;
    `CHK(state_addr, a)
    `CHK(counter_value, c)
  endtask
  task t_boot;
    for (k = 0; k < 3; k++) step(8'h00, 8'h00);
    for (k = 1; k < 12; k++) step(k[7:0], 8'h00);
    step(8'h0c, 8'h00);
    `CHK(user_outputs, 8'h0c)
  endtask
  task t_loop;
    step(8'h10, 8'h03);
    step(8'h10, 8'h02);
    step(8'h10, 8'h01);
    step(8'h10, 8'h00);
    `CHK(counter_zero, 1'b1)
    step(8'h11, 8'h00);
    step(8'h12, 8'h00);
  endtask
  task t_stack;
    step(8'h20, 8'h00);
    step(8'h21, 8'h09);
    step(8'h22, 8'h05);
    step(8'h23, 8'h04);
    step(8'h24, 8'h09);
    step(8'h25, 8'h08);
    step(8'h30, 8'h08);
    step(8'h13, 8'h08);
  endtask
  task t_inputs;
    step(8'h14, 8'h08);
    step(8'h40, 8'h08);
    step(8'hca, 8'h08);
    `CHK(user_outputs, 8'hca)
    step(8'h50, 8'h08);
    step(8'h50, 8'h08);
  endtask
  task t_secure;
    readback_req = 1'b1;
    readback_addr = 8'h10;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(readback_data, 32'h0511_1010)
    security_bit = 1'b1;
    repeat (3) @(posedge core_clk);
    #1;
    `CHK(secured, 1'b1)
    `CHK(readback_data, 32'h0000_0000)
    readback_req = 1'b0;
    full_erase = 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    `CHK(secured, 1'b0)
    security_bit = 1'b0;
    full_erase = 1'b0;
  endtask
  task t_super;
    active_low_reset = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    active_low_reset = 1'b1;
    for (k = 0; k < 12 && supervisor_entry !== 1'b1; k++) @(posedge core_clk);
    #1;
    `CHK(supervisor_entry, 1'b1)
    `CHK(prom_addr, 8'h00)
  endtask
  initial begin
    resetn = 1'b0;
    active_low_reset = 1'b1;
    security_bit = 1'b0;
    full_erase = 1'b0;
    readback_req = 1'b0;
    readback_addr = 8'h00;
    repeat (16) @(posedge core_clk);
    #1;
    resetn = 1'b1;
    t_boot;
    t_loop;
    t_stack;
    t_inputs;
    t_secure;
    t_super;
    finish_test;
  end
  // The whole sequence needs well under a thousand cycles
  initial begin
    #4000;
    bad_count++;
    finish_test;
  end
endmodule // tb_top
`default_nettype wire
